/* File: hdl/fcs_core.sv */
// Flash command sequencer: host write decoder and mode control
`timescale 1ns/100ps
module fcs_core #(
	parameter logic [15:0] MAKER_CODE = 16'h005A, // Arbitrary value
	parameter logic [15:0] PART_CODE = 16'h1234, // Arbitrary value
	parameter int BLK_W = 9
) (
	input wire logic clk,
	input wire logic rst,
	input wire fcs_pkg::fcs_wr_s host_wr,
	input wire fcs_pkg::fcs_rd_s host_rd,
	input wire logic vpp_high_pin,
	input wire logic op_done,
	input wire logic operation_fail_flag,
	output fcs_pkg::fcs_cmd_s cmd,
	output fcs_pkg::fcs_mode_s mode,
	output logic [15:0] rd_data,
	output logic rd_ok,
	output logic fail_seen
);
	import fcs_pkg::*;

	typedef struct packed {
		fcs_seq_e seq;
		fcs_mode_s mode;
		logic fail;
		logic chip;
		logic [1:0] qcnt;
		logic [ADDR_W-1:QUAD_LO] qbase;
		logic [BLK_W-1:0] eblk;
		fcs_cmd_s cmd;
		logic [15:0] rd_data;
		logic rd_ok;
	} fcs_core_s;

	fcs_core_s s;
	fcs_core_s next_s;
	logic vpp_high;
	logic prot_bit;
	logic otp_locked;
	logic prot_we;
	logic prot_val;
	logic [7:0] wd;
	logic [BANK_HI-BANK_LO:0] wbank;
	logic [BLK_W-1:0] wblk;

	// Command match on low byte and low address bits only
	function automatic logic hit(input fcs_wr_s w, input logic [10:0] a,
		input logic [7:0] c);
		hit = (w.addr[UNLOCK_W-1:0] == a) && (w.data[7:0] == c);
	endfunction

	fcs_sync #(
		.W(1)
	) u_vpp_sync (
		.clk(clk),
		.rst(rst),
		.pin(vpp_high_pin),
		.level(vpp_high)
	);

	fcs_prot #(
		.BLK_W(BLK_W)
	) u_prot (
		.clk(clk),
		.rst(rst),
		.wr_en(prot_we),
		.wr_otp(s.mode.otp),
		.wr_blk(wblk),
		.wr_val(prot_val),
		.rd_blk(host_rd.addr[BLK_LO+BLK_W-1:BLK_LO]),
		.rd_prot(prot_bit),
		.otp_locked(otp_locked)
	);

	assign wd = host_wr.data[7:0];
	assign wbank = host_wr.addr[BANK_HI:BANK_LO];
	assign wblk = host_wr.addr[BLK_LO+BLK_W-1:BLK_LO];
	assign prot_we = host_wr.valid && (s.seq == SQ_PROT2) &&
		(wd == CD_PROTECT) && host_wr.addr[1] && !host_wr.addr[0];
	assign prot_val = !host_wr.addr[PROT_SEL_BIT];

	always_comb begin
		next_s = s;
		next_s.cmd.valid = 1'b0;
		next_s.cmd.kind = CK_NONE;
		next_s.rd_ok = 1'b0;
		if (op_done) begin
			next_s.mode.run = OP_NONE;
			next_s.chip = 1'b0;
		end
		if (host_wr.valid) begin
			next_s.seq = SQ_IDLE;
			next_s.cmd.addr = host_wr.addr;
			next_s.cmd.data = host_wr.data;
			case (s.seq)
				SQ_IDLE: begin
					if (wd == CD_RESET) begin
						next_s.cmd.valid = 1'b1;
						next_s.cmd.kind = CK_RESET;
						next_s.mode.ident = 1'b0;
						next_s.mode.cfi = 1'b0;
						if (s.fail) begin
							next_s.fail = 1'b0;
							next_s.mode.run = OP_NONE;
							next_s.mode.susp =
								(s.mode.susp == OP_ERASE) ? OP_ERASE : OP_NONE;
						end
					end else if (s.mode.run != OP_NONE) begin
						// Only reset and suspend are heard while an operation runs
						if (wd == CD_SUSPEND && s.mode.susp == OP_NONE &&
							!(s.mode.run == OP_ERASE && s.chip)) begin
							next_s.cmd.valid = 1'b1;
							next_s.cmd.kind = CK_SUSPEND;
							next_s.mode.susp = s.mode.run;
							next_s.mode.run = OP_NONE;
							next_s.mode.bank = wbank;
						end
					end else if (s.mode.bypass) begin
						case (wd)
							CD_PROGRAM: next_s.seq = SQ_BPROG;
							CD_ERASE: next_s.seq = SQ_BERASE;
							CD_IDENT: next_s.seq = SQ_BEXIT;
							default: next_s.mode.bypass = 1'b0;
						endcase
					end else if (hit(host_wr, UNLOCK_A1, CD_UNLOCK1)) begin
						next_s.seq = SQ_U1;
					end else if (wd == CD_RESUME && s.mode.susp != OP_NONE) begin
						next_s.cmd.valid = 1'b1;
						next_s.cmd.kind = CK_RESUME;
						next_s.mode.run = s.mode.susp;
						next_s.mode.susp = OP_NONE;
						next_s.mode.ident = 1'b0;
					end else if (wd == CD_QUAD && vpp_high) begin
						next_s.seq = SQ_QUAD;
						next_s.qcnt = 2'h0;
					end else if (wd == CD_PROTECT) begin
						next_s.seq = SQ_PROT1;
					end else if (wd == CD_CFI &&
						host_wr.addr[7:0] == OFS_CFI &&
						s.mode.susp == OP_NONE) begin
						next_s.mode.cfi = 1'b1;
						next_s.mode.bank = wbank;
					end else begin
						next_s.mode.ident = 1'b0;
						next_s.mode.cfi = 1'b0;
					end
				end
				SQ_U1: begin
					if (hit(host_wr, UNLOCK_A2, CD_UNLOCK2)) begin
						next_s.seq = SQ_U2;
					end else begin
						next_s.mode.ident = 1'b0;
					end
				end
				SQ_U2: begin
					if (host_wr.addr[UNLOCK_W-1:0] != UNLOCK_A1) begin
						next_s.mode.ident = 1'b0;
					end else begin
						case (wd)
							CD_IDENT: begin
								next_s.mode.ident = 1'b1;
								next_s.mode.cfi = 1'b0;
								next_s.mode.bank = wbank;
							end
							CD_PROGRAM: next_s.seq = SQ_PROG;
							CD_BYPASS: begin
								next_s.mode.bypass = 1'b1;
							end
							CD_ERASE: begin
								if (s.mode.susp == OP_NONE) begin
									next_s.seq = SQ_E1;
								end
							end
							CD_BURST: begin
								next_s.cmd.valid = 1'b1;
								next_s.cmd.kind = CK_BURST;
							end
							CD_OTP_IN: next_s.mode.otp = 1'b1;
							CD_OTP_OUT: begin
								if (s.mode.otp) begin
									next_s.seq = SQ_OTPX;
								end
							end
							default: next_s.mode.ident = 1'b0;
						endcase
					end
				end
				SQ_PROG, SQ_BPROG: begin
					if (s.mode.susp == OP_ERASE && wblk == s.eblk) begin
						next_s.mode.ident = 1'b0;
					end else begin
						next_s.cmd.valid = 1'b1;
						next_s.cmd.kind = CK_PROG;
						next_s.mode.run = OP_PROG;
					end
				end
				SQ_E1: begin
					if (hit(host_wr, UNLOCK_A1, CD_UNLOCK1)) begin
						next_s.seq = SQ_E2;
					end
				end
				SQ_E2: begin
					if (hit(host_wr, UNLOCK_A2, CD_UNLOCK2)) begin
						next_s.seq = SQ_E3;
					end
				end
				SQ_E3, SQ_BERASE: begin
					if ((s.seq == SQ_BERASE || host_wr.addr[UNLOCK_W-1:0] ==
						UNLOCK_A1) && wd == CD_CHIP &&
						s.mode.susp == OP_NONE) begin
						next_s.cmd.valid = 1'b1;
						next_s.cmd.kind = CK_CERASE;
						next_s.mode.run = OP_ERASE;
						next_s.chip = 1'b1;
					end else if (wd == CD_BLOCK && s.mode.susp == OP_NONE) begin
						next_s.cmd.valid = 1'b1;
						next_s.cmd.kind = CK_BERASE;
						next_s.mode.run = OP_ERASE;
						next_s.chip = 1'b0;
						next_s.eblk = wblk;
					end else begin
						next_s.mode.bypass = 1'b0;
					end
				end
				SQ_BEXIT: begin
					next_s.mode.bypass = 1'b0;
				end
				SQ_QUAD: begin
					if (!vpp_high || (s.qcnt != 2'h0 &&
						host_wr.addr[ADDR_W-1:QUAD_LO] != s.qbase)) begin
						next_s.seq = SQ_IDLE;
					end else begin
						next_s.cmd.valid = 1'b1;
						next_s.qbase = host_wr.addr[ADDR_W-1:QUAD_LO];
						next_s.qcnt = s.qcnt + 2'h1;
						if (s.qcnt == QUAD_LAST_IDX) begin
							next_s.cmd.kind = CK_QUAD_LAST;
							next_s.mode.run = OP_PROG;
						end else begin
							next_s.cmd.kind = CK_QUAD;
							next_s.seq = SQ_QUAD;
						end
					end
				end
				SQ_PROT1: begin
					if (wd == CD_PROTECT) begin
						next_s.seq = SQ_PROT2;
					end
				end
				SQ_PROT2: begin
					if (prot_we) begin
						next_s.cmd.valid = 1'b1;
						next_s.cmd.kind = prot_val ? CK_PROTECT : CK_UNPROTECT;
					end
				end
				SQ_OTPX: begin
					if (wd == CD_ZERO) begin
						next_s.mode.otp = 1'b0;
					end
				end
				default: next_s.seq = SQ_IDLE;
			endcase
		end
		// A failure that coincides with the reset is kept
		if (operation_fail_flag && s.mode.run != OP_NONE) begin
			next_s.fail = 1'b1;
		end
		if (host_rd.valid && s.mode.ident &&
			host_rd.addr[BANK_HI:BANK_LO] == s.mode.bank) begin
			next_s.rd_ok = 1'b1;
			case (host_rd.addr[7:0])
				OFS_MAKER: next_s.rd_data = MAKER_CODE;
				OFS_PART: next_s.rd_data = PART_CODE;
				OFS_PROT: begin
					if (s.mode.otp) begin
						next_s.rd_data = otp_locked ? PROT_ON : PROT_OFF;
					end else begin
						next_s.rd_data = prot_bit ? PROT_ON : PROT_OFF;
					end
				end
				default: begin
					next_s.rd_ok = 1'b0;
					next_s.rd_data = RD_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign cmd = s.cmd;
	assign mode = s.mode;
	assign rd_data = s.rd_data;
	assign rd_ok = s.rd_ok;
	assign fail_seen = s.fail;

	AST_BAD_SECOND: assert property (@(posedge clk) disable iff (rst)
		(host_wr.valid && s.seq == SQ_U1 &&
		!hit(host_wr, UNLOCK_A2, CD_UNLOCK2)) |=>
		(s.seq == SQ_IDLE && !s.mode.ident && !s.cmd.valid))
		else $error("bad second write not abandoned");
	AST_RESET_IDENT: assert property (@(posedge clk) disable iff (rst)
		(host_wr.valid && s.seq == SQ_IDLE && wd == CD_RESET && !s.fail &&
		s.mode.ident) |=> (!s.mode.ident &&
		s.mode.susp == $past(s.mode.susp) && cmd.kind == CK_RESET))
		else $error("reset left identification wrongly");
	AST_MAKER_READ: assert property (@(posedge clk) disable iff (rst)
		(host_rd.valid && s.mode.ident && host_rd.addr[7:0] == OFS_MAKER &&
		host_rd.addr[BANK_HI:BANK_LO] == s.mode.bank) |=>
		(rd_ok && rd_data == MAKER_CODE))
		else $error("maker code read wrong");
	AST_PROT_READ: assert property (@(posedge clk) disable iff (rst)
		(host_rd.valid && s.mode.ident && !s.mode.otp &&
		host_rd.addr[7:0] == OFS_PROT &&
		host_rd.addr[BANK_HI:BANK_LO] == s.mode.bank) |=>
		(rd_data == ($past(prot_bit) ? PROT_ON : PROT_OFF)))
		else $error("protection status read wrong");
	AST_PROG_START: assert property (@(posedge clk) disable iff (rst)
		(host_wr.valid && s.seq == SQ_PROG && s.mode.susp == OP_NONE) |=>
		(cmd.valid && cmd.kind == CK_PROG &&
		cmd.addr == $past(host_wr.addr) && s.mode.run == OP_PROG))
		else $error("program not started on fourth write");
	AST_QUAD_SUPPLY: assert property (@(posedge clk) disable iff (rst)
		(cmd.valid && cmd.kind == CK_QUAD_LAST) |->
		($past(vpp_high) && $past(s.qcnt) == QUAD_LAST_IDX))
		else $error("quad program without supply or count");
	AST_SUSPEND: assert property (@(posedge clk) disable iff (rst)
		(cmd.valid && cmd.kind == CK_SUSPEND) |->
		(s.mode.run == OP_NONE && s.mode.susp != OP_NONE &&
		!($past(s.chip) && s.mode.susp == OP_ERASE)))
		else $error("suspend taken in wrong state");
	AST_RESUME: assert property (@(posedge clk) disable iff (rst)
		(cmd.valid && cmd.kind == CK_RESUME) |->
		($past(s.mode.susp) != OP_NONE &&
		s.mode.run == $past(s.mode.susp)))
		else $error("resume without matching suspend");
	AST_CFI_ENTRY: assert property (@(posedge clk) disable iff (rst)
		$rose(s.mode.cfi) |-> ($past(s.mode.susp) == OP_NONE &&
		$past(s.mode.run) == OP_NONE && $past(wd) == CD_CFI))
		else $error("query entered from wrong mode");
endmodule // fcs_core

/* File: hdl/fcs_pkg.sv */
// Constants, types and carriers of the flash command sequencer
package fcs_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int UNLOCK_W = 11;
	localparam int BANK_HI = 20;
	localparam int BANK_LO = 17;
	localparam int BLK_LO = 12;
	localparam int QUAD_LO = 2;
	localparam int PROT_SEL_BIT = 6;
	localparam int CFG_LO = 11;
	localparam logic [10:0] UNLOCK_A1 = 11'h555;
	localparam logic [10:0] UNLOCK_A2 = 11'h2AA;
	localparam logic [7:0] CD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CD_RESET = 8'hF0;
	localparam logic [7:0] CD_IDENT = 8'h90;
	localparam logic [7:0] CD_PROGRAM = 8'hA0;
	localparam logic [7:0] CD_BYPASS = 8'h20;
	localparam logic [7:0] CD_ERASE = 8'h80;
	localparam logic [7:0] CD_CHIP = 8'h10;
	localparam logic [7:0] CD_BLOCK = 8'h30;
	localparam logic [7:0] CD_RESUME = 8'h30;
	localparam logic [7:0] CD_QUAD = 8'hA5;
	localparam logic [7:0] CD_SUSPEND = 8'hB0;
	localparam logic [7:0] CD_PROTECT = 8'h60;
	localparam logic [7:0] CD_CFI = 8'h98;
	localparam logic [7:0] CD_BURST = 8'hC0;
	localparam logic [7:0] CD_OTP_IN = 8'h70;
	localparam logic [7:0] CD_OTP_OUT = 8'h75;
	localparam logic [7:0] CD_ZERO = 8'h00;
	localparam logic [7:0] OFS_MAKER = 8'h00;
	localparam logic [7:0] OFS_PART = 8'h01;
	localparam logic [7:0] OFS_PROT = 8'h02;
	localparam logic [7:0] OFS_CFI = 8'h55;
	localparam logic [15:0] PROT_OFF = 16'h0000;
	localparam logic [15:0] PROT_ON = 16'h0001;
	localparam logic [15:0] RD_RESET = 16'h0000;
	localparam logic [1:0] QUAD_LAST_IDX = 2'h3;
	typedef enum logic [3:0] {
		SQ_IDLE = 4'b0000, SQ_U1 = 4'b0001, SQ_U2 = 4'b0010,
		SQ_PROG = 4'b0011, SQ_E1 = 4'b0100, SQ_E2 = 4'b0101,
		SQ_E3 = 4'b0110, SQ_BPROG = 4'b0111, SQ_BERASE = 4'b1000,
		SQ_BEXIT = 4'b1001, SQ_QUAD = 4'b1010, SQ_PROT1 = 4'b1011,
		SQ_PROT2 = 4'b1100, SQ_OTPX = 4'b1101
	} fcs_seq_e;
	typedef enum logic [1:0] {
		OP_NONE = 2'b00, OP_PROG = 2'b01, OP_ERASE = 2'b10
	} fcs_op_e;
	typedef enum logic [3:0] {
		CK_NONE = 4'b0000, CK_PROG = 4'b0001, CK_QUAD = 4'b0010,
		CK_QUAD_LAST = 4'b0011, CK_BERASE = 4'b0100, CK_CERASE = 4'b0101,
		CK_SUSPEND = 4'b0110, CK_RESUME = 4'b0111, CK_PROTECT = 4'b1000,
		CK_UNPROTECT = 4'b1001, CK_BURST = 4'b1010, CK_RESET = 4'b1011
	} fcs_cmd_e;
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fcs_wr_s;
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
	} fcs_rd_s;
	typedef struct packed {
		logic valid;
		fcs_cmd_e kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fcs_cmd_s;
	typedef struct packed {
		logic ident;
		logic cfi;
		logic bypass;
		logic otp;
		fcs_op_e run;
		fcs_op_e susp;
		logic [BANK_HI-BANK_LO:0] bank;
	} fcs_mode_s;
endpackage

/* File: hdl/fcs_prot.sv */
// Per-block protection bits and the one-time region lock
`timescale 1ns/100ps
module fcs_prot #(
	parameter int BLK_W = 9
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic wr_otp,
	input wire logic [BLK_W-1:0] wr_blk,
	input wire logic wr_val,
	input wire logic [BLK_W-1:0] rd_blk,
	output logic rd_prot,
	output logic otp_locked
);
	logic prot [2**BLK_W];
	logic otp_lock;
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 2**BLK_W; i++) begin
				prot[i] <= 1'b0;
			end
			otp_lock <= 1'b0;
		end else if (wr_en) begin
			// Region lock only ever sets
			if (wr_otp) begin
				otp_lock <= otp_lock | wr_val;
			end else begin
				prot[wr_blk] <= wr_val;
			end
		end
	end
	assign rd_prot = prot[rd_blk];
	assign otp_locked = otp_lock;
endmodule // fcs_prot

/* File: hdl/fcs_sync.sv */
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module fcs_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} fcs_sync_s;
	fcs_sync_s s;
	fcs_sync_s next_s;
	always_comb begin
		next_s.meta = pin;
		next_s.stable = s.meta;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign level = s.stable;
endmodule // fcs_sync

/* File: tb/fcs_host.sv */
// Host-side model issuing word writes and status reads
`timescale 1ns/100ps
module fcs_host (
	input wire logic clk,
	output fcs_pkg::fcs_wr_s host_wr,
	output fcs_pkg::fcs_rd_s host_rd
);
	import fcs_pkg::*;
	initial begin
		host_wr = '0;
		host_rd = '0;
	end
	// Released bus shows inverted levels, never stale values
	task automatic wr(input logic [20:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		host_wr = '{1'b1, a, d};
		@(posedge clk);
		#1;
		host_wr = '{1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [20:0] a);
		@(posedge clk);
		#1;
		host_rd = '{1'b1, a};
		@(posedge clk);
		#1;
		host_rd = '{1'b0, ~a};
	endtask
endmodule // fcs_host

/* File: tb/flash_command_sequencer_tb.sv */
// Self-checking bench for the flash command sequencer
`timescale 1ns/100ps
module flash_command_sequencer_tb;
	import fcs_pkg::*;
	localparam logic [15:0] MK = 16'h3C5E; // Arbitrary value
	localparam logic [15:0] PK = 16'h7A1D; // Arbitrary value
	logic clk = 1'b0;
	logic rst = 1'b1;
	fcs_wr_s host_wr;
	fcs_rd_s host_rd;
	logic vpp_high_pin = 1'b0;
	logic op_done = 1'b0;
	logic operation_fail_flag = 1'b0;
	fcs_cmd_s cmd;
	fcs_mode_s mode;
	logic [15:0] rd_data;
	logic rd_ok;
	logic fail_seen;
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [8:0] blk;
	logic [20:0] a;
	logic [20:0] pa;
	logic [15:0] d;
	logic [15:0] pd;
	fcs_host fcs_host_i (.clk(clk), .host_wr(host_wr), .host_rd(host_rd));
	fcs_core #(.MAKER_CODE(MK), .PART_CODE(PK)) fcs_core_i (
		.clk(clk), .rst(rst), .host_wr(host_wr), .host_rd(host_rd),
		.vpp_high_pin(vpp_high_pin), .op_done(op_done),
		.operation_fail_flag(operation_fail_flag), .cmd(cmd),
		.mode(mode), .rd_data(rd_data), .rd_ok(rd_ok),
		.fail_seen(fail_seen));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			wrap_up();
		end
	end
	function automatic logic [9:0] r10();
		return 10'($urandom);
	endfunction
	function automatic logic [20:0] ra();
		return 21'($urandom);
	endfunction
	task automatic wrap_up();
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cmp_cmd(input fcs_cmd_e k, input logic [20:0] ea,
		input logic [15:0] ed);
		fcs_cmd_s e;
		e = '{1'b1, k, ea, ed};
		checks_done++;
		if (cmd !== e) begin
			bad_count++;
			$display("unexpected cmd at %0t: %h want %h", $time, cmd, e);
		end
	endtask
	task automatic cmp_val(input logic [20:0] e, input logic [20:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected value at %0t: %h want %h", $time, g, e);
		end
	endtask
	task automatic one(input logic [20:0] ea, input logic [7:0] c);
		a = ea;
		d = {8'($urandom), c};
		fcs_host_i.wr(a, d);
	endtask
	// Upper address and data bits randomised in unlock cycles
	task automatic unl2();
		fcs_host_i.wr({r10(), UNLOCK_A1}, {8'($urandom), CD_UNLOCK1});
		fcs_host_i.wr({r10(), UNLOCK_A2}, {8'($urandom), CD_UNLOCK2});
	endtask
	task automatic unl(input logic [7:0] c, input logic [9:0] hi);
		unl2();
		one({hi, UNLOCK_A1}, c);
	endtask
	task automatic erase6(input logic [7:0] c, input logic [20:0] ea);
		unl(CD_ERASE, r10());
		unl2();
		one(ea, c);
	endtask
	task automatic rdi(input logic [20:0] ea, input logic [15:0] e);
		fcs_host_i.rd(ea);
		cmp_val(21'(1), 21'(rd_ok));
		cmp_val(21'(e), 21'(rd_data));
	endtask
	task automatic done();
		@(posedge clk);
		#1;
		op_done = 1'b1;
		@(posedge clk);
		#1;
		op_done = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic prog();
		pa = ra();
		pd = 16'($urandom);
		unl(CD_PROGRAM, r10());
		fcs_host_i.wr(pa, pd);
	endtask
	initial begin
		void'($urandom(92));
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		cmp_val(21'(0), 21'(mode));
		cmp_val(21'(0), 21'({cmd.valid, rd_ok, fail_seen, rd_data}));
		repeat (20) begin
			prog();
			cmp_cmd(CK_PROG, pa, pd);
			cmp_val(21'(OP_PROG), 21'(mode.run));
			done();
			cmp_val(21'(OP_NONE), 21'(mode.run));
		end
		prog();
		operation_fail_flag = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		operation_fail_flag = 1'b0;
		cmp_val(21'(1), 21'(fail_seen));
		one(ra(), CD_RESET);
		cmp_cmd(CK_RESET, a, d);
		cmp_val(21'(0), 21'({fail_seen, mode.run}));
		blk = 9'($urandom);
		for (int i = 0; i < 2; i++) begin
			one(ra(), CD_PROTECT);
			one(ra(), CD_PROTECT);
			one({blk, 5'h00, i[0], 4'h0, 2'b10}, CD_PROTECT);
			cmp_cmd(i == 1 ? CK_UNPROTECT : CK_PROTECT, a, d);
			unl(CD_IDENT, {blk[8:5], 6'($urandom)});
			cmp_val(21'(1), 21'(mode.ident));
			cmp_val(21'(blk[8:5]), 21'(mode.bank));
			rdi({blk, 4'h0, OFS_MAKER}, MK);
			rdi({blk, 4'h0, OFS_PART}, PK);
			rdi({blk, 4'h0, OFS_PROT}, i == 1 ? PROT_OFF : PROT_ON);
			one(ra(), CD_RESET);
			cmp_val(21'(0), 21'(mode.ident));
		end
		unl2();
		one(21'h0_0123, CD_IDENT);
		cmp_val(21'(0), 21'(mode.ident));
		// Wrong second address drops the sequence
		fcs_host_i.wr({r10(), UNLOCK_A1}, {8'($urandom), CD_UNLOCK1});
		one({r10(), UNLOCK_A1}, CD_UNLOCK2);
		one({blk[8:5], 6'($urandom), UNLOCK_A1}, CD_IDENT);
		cmp_val(21'(0), 21'(mode.ident));
		one(ra(), CD_PROGRAM);
		fcs_host_i.wr(ra(), {8'($urandom), CD_ZERO});
		cmp_val(21'(0), 21'(cmd.valid));
		unl(CD_BYPASS, r10());
		cmp_val(21'(1), 21'(mode.bypass));
		one(ra(), CD_PROGRAM);
		fcs_host_i.wr(pa, pd);
		cmp_cmd(CK_PROG, pa, pd);
		done();
		one(ra(), CD_ERASE);
		one({blk, 12'h000}, CD_BLOCK);
		cmp_cmd(CK_BERASE, a, d);
		done();
		one(ra(), CD_ERASE);
		one(ra(), CD_CHIP);
		cmp_cmd(CK_CERASE, a, d);
		done();
		one(ra(), CD_IDENT);
		one(ra(), CD_ZERO);
		cmp_val(21'(0), 21'(mode.bypass));
		erase6(CD_BLOCK, {blk, 12'h000});
		cmp_cmd(CK_BERASE, a, d);
		cmp_val(21'(OP_ERASE), 21'(mode.run));
		one({blk[8:5], 17'($urandom)}, CD_SUSPEND);
		cmp_cmd(CK_SUSPEND, a, d);
		cmp_val(21'(OP_ERASE), 21'(mode.susp));
		unl(CD_PROGRAM, r10());
		fcs_host_i.wr({blk, 12'h034}, pd);
		cmp_val(21'(0), 21'(cmd.valid));
		unl(CD_PROGRAM, r10());
		pa = {~blk, 12'($urandom)};
		fcs_host_i.wr(pa, pd);
		cmp_cmd(CK_PROG, pa, pd);
		done();
		unl(CD_IDENT, {blk[8:5], 6'($urandom)});
		cmp_val(21'(1), 21'(mode.ident));
		one(ra(), CD_RESET);
		cmp_val(21'(OP_ERASE), 21'(mode.susp));
		one({blk[8:5], 17'($urandom)}, CD_RESUME);
		cmp_cmd(CK_RESUME, a, d);
		cmp_val(21'(OP_NONE), 21'(mode.susp));
		done();
		one(ra(), CD_RESUME);
		cmp_val(21'(0), 21'(cmd.valid));
		erase6(CD_CHIP, {r10(), UNLOCK_A1});
		cmp_cmd(CK_CERASE, a, d);
		one(ra(), CD_SUSPEND);
		cmp_val(21'(0), 21'(cmd.valid));
		done();
		prog();
		one(ra(), CD_SUSPEND);
		cmp_val(21'(OP_PROG), 21'(mode.susp));
		one(ra(), CD_RESUME);
		cmp_cmd(CK_RESUME, a, d);
		done();
		vpp_high_pin = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		one(ra(), CD_QUAD);
		for (int i = 0; i < 4; i++) begin
			a = {pa[20:2], 2'(i)};
			d = 16'($urandom);
			fcs_host_i.wr(a, d);
			cmp_cmd(i == 3 ? CK_QUAD_LAST : CK_QUAD, a, d);
		end
		done();
		vpp_high_pin = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		one(ra(), CD_QUAD);
		fcs_host_i.wr(pa, {pd[15:8], CD_ZERO});
		cmp_val(21'(0), 21'(cmd.valid));
		one({4'($urandom), 9'($urandom), OFS_CFI}, CD_CFI);
		cmp_val(21'(1), 21'(mode.cfi));
		one(ra(), CD_RESET);
		cmp_val(21'(0), 21'(mode.cfi));
		unl(CD_BURST, r10());
		cmp_cmd(CK_BURST, a, d);
		unl(CD_OTP_IN, r10());
		cmp_val(21'(1), 21'(mode.otp));
		unl(CD_IDENT, {blk[8:5], 6'($urandom)});
		rdi({blk, 4'h0, OFS_PROT}, PROT_OFF);
		// Protect inside the region locks it
		one(ra(), CD_PROTECT);
		one(ra(), CD_PROTECT);
		one({blk, 5'h00, 1'b0, 4'h0, 2'b10}, CD_PROTECT);
		cmp_cmd(CK_PROTECT, a, d);
		rdi({blk, 4'h0, OFS_PROT}, PROT_ON);
		one(ra(), CD_RESET);
		unl(CD_OTP_OUT, r10());
		one(ra(), CD_ZERO);
		cmp_val(21'(0), 21'(mode.otp));
		wrap_up();
	end
endmodule // flash_command_sequencer_tb
